// ### core/e1tpc_map.svh
// Offsets, field positions, reset values and timing counts of the slot conditioner
`ifndef E1TPC_MAP_SVH
`define E1TPC_MAP_SVH

// ********************************************************
// Direct register offsets and reset values
// ********************************************************
`define E1TPC_OFF_CONFIG 8'h60
`define E1TPC_OFF_STATUS 8'h61
`define E1TPC_OFF_ADDRCMD 8'h62
`define E1TPC_OFF_DATABUF 8'h63
`define E1TPC_RESET_BYTE 8'h00

// ********************************************************
// Field positions
// ********************************************************
`define E1TPC_CFG_ENABLE 0
`define E1TPC_STAT_BUSY 7
`define E1TPC_CMD_READ 7
`define E1TPC_CTL_SUBST 7
`define E1TPC_CTL_DSHIGH 5
`define E1TPC_CTL_DSLOW 4
`define E1TPC_CTL_TEST 3
`define E1TPC_CTL_LOOP 2
`define E1TPC_SIG_SOURCE 4

// ********************************************************
// Inversion masks and milliwatt sequences, first sample in the low byte
// ********************************************************
`define E1TPC_MASK_ODD 8'h55
`define E1TPC_MASK_EVEN 8'haa
`define E1TPC_MASK_ALL 8'hff
`define E1TPC_MW_ALAW 64'hb4a1a1b4_34212134
`define E1TPC_MW_ULAW 64'h9e8b8b9e_1e0b0b1e

// ********************************************************
// Indirect access timing
// ********************************************************
`define E1TPC_CYCLE_NS 490
`define E1TPC_CLK_NS 4
`define E1TPC_CYCLE_CLKS (`E1TPC_CYCLE_NS / `E1TPC_CLK_NS)

`endif

// ### core/e1tpc_pkg.sv
// Types shared by the transmit slot conditioner
package e1tpc_pkg;

   // ********************************************************
   // Conditioned slot word, as carried through the FIFO
   // ********************************************************
   typedef struct packed {
      logic [4:0] slot;
      logic [3:0] sig;
      logic [7:0] data;
   } e1tpc_word_s;

   // ********************************************************
   // Microprocessor request
   // ********************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] data;
   } e1tpc_up_s;

   // Action chosen for one slot
   typedef enum logic [2:0] {
      ACT_PASS, ACT_EXTRACT, ACT_LOOP, ACT_MW, ACT_PATTERN, ACT_IDLE, ACT_INVERT
   } e1tpc_act_e;

   // Indirect access sequencer
   typedef enum logic {ST_IDLE, ST_BUSY} e1tpc_state_e;

   // Indirect region decode
   typedef enum logic [1:0] {REG_NONE, REG_CTRL, REG_IDLE, REG_SIG} e1tpc_region_e;

endpackage

// ### core/e1tpc_conditioner.sv
// E1 transmit per-slot payload conditioner with its output FIFO
//
// How it works
// - A read command places the indirect byte in the data buffer within 490 ns.
// - Indirect 20-3F control, 40-5F idle code, 61-7F signalling bytes.
// - Without substitution, data select passes, inverts odd, even or all bits.
// - Substitution with low select clear sends the slot idle code.
// - Substitution with low select set sends A-law or mu-law milliwatt.
// - Test bit extracts to detector or inserts generated pattern by direction.
// - Extracted slots form one stream; inserted slots draw one sequence.
// - Loop bit in receive master mode sends aligned received payload.
// - In slave mode loopback needs matching clocks and frame pulses.
// - Priority: extract, loop, milliwatt, pattern, idle, inversion.
// - Idle code replaces input data, bit 7 sent first.
// - Under CAS, source bit picks pin signalling or stored ABCD.
// - Stored ABCD sit in the low nibble, A at bit 3.
// - Writing address/command starts one indirect access cycle.
// - Busy stays high for the whole cycle; host waits for it to clear.
// - Function enable low passes data without per-slot processing.
`timescale 1ns/1ps
`default_nettype none
`include "e1tpc_map.svh"

// ********************************************************
// Flip-flop FIFO, pointers wrap so DEPTH must be a power of two
// ********************************************************
module e1tpc_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   // Honest flags from the occupancy count
   assign inReady = (count_reg != AW'(0) + (AW+1)'(DEPTH));
   assign outValid = (count_reg != '0);
   assign outData = mem_reg[rdPtr_reg];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // Storage
   always_ff @(posedge mclk) begin
      if (ce && push) begin
         mem_reg[wrPtr_reg] <= inData;
      end
   end

   // Pointers and count
   always_ff @(posedge mclk) begin
      if (reset) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else if (ce) begin
         if (push) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (pop) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

// ********************************************************
// Top: serial transmit slots in, conditioned slot words out
// ********************************************************
module e1tpc_conditioner
   import e1tpc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire e1tpc_up_s upReq,
   output logic [7:0] upRdData_reg,
   input wire logic transmitSystemClock,
   input wire logic transmitFramePulse,
   input wire logic transmitSystemDataInput,
   input wire logic transmitSignallingInput,
   input wire logic patternDirectionSelect,
   input wire logic casEnabled,
   input wire logic rxClockMaster,
   input wire logic slaveClocksShared,
   input wire logic [7:0] loopRxByte,
   input wire logic [7:0] patGenByte,
   output logic patGenTake_reg,
   output logic [7:0] patDetByte_reg,
   output logic patDetValid_reg,
   output e1tpc_word_s outWord_reg,
   output logic outValid_reg,
   input wire logic outReady,
   output logic fifoRoom_reg,
   output logic overflow_reg
);
   // Direct registers
   logic perSlotEnable_reg;
   logic [7:0] addrCmd_reg;
   logic [7:0] dataBuf_reg;
   e1tpc_state_e state_reg;
   logic [7:0] cycleCnt_reg;
   // Indirect storage
   logic [7:0] slotCtrl_reg [32];
   logic [7:0] slotIdle_reg [32];
   logic [7:0] slotSig_reg [32];
   // Pin synchronisers and framing
   logic [3:0] pinS1_reg;
   logic [3:0] pinS2_reg;
   logic clkPrev_reg;
   logic [2:0] bitCnt_reg;
   logic [4:0] slot_reg;
   logic [2:0] mwPhase_reg;
   logic [6:0] dataShift_reg;
   logic [2:0] sigShift_reg;
   logic [7:0] curCtrl_reg;
   logic [7:0] curIdle_reg;
   logic [7:0] curSig_reg;
   // Pending word for the FIFO
   e1tpc_word_s pend_reg;
   logic pendValid_reg;
   // Combinational
   logic sysEdge;
   logic framePin;
   logic [2:0] curBit;
   logic [4:0] curSlot;
   logic [7:0] fullByte;
   logic [3:0] fullSig;
   e1tpc_act_e action;
   logic [7:0] condByte;
   logic [3:0] condSig;
   e1tpc_word_s fifoOut;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoPop;
   logic upCmdWrite;
   logic [6:0] indAddr;

   // Map a 7-bit indirect address onto its storage region
   function automatic e1tpc_region_e regionOf(input logic [6:0] a);
      if (a[6:5] == 2'b01) begin
         return REG_CTRL;
      end else if (a[6:5] == 2'b10) begin
         return REG_IDLE;
      end else if (a[6:5] == 2'b11 && a[4:0] != 5'h00) begin
         return REG_SIG;
      end else begin
         return REG_NONE;
      end
   endfunction

   // Pick one action by fixed priority
   function automatic e1tpc_act_e pickAction(input logic [7:0] c, input logic dir,
                                             input logic loopOk);
      if (c[`E1TPC_CTL_TEST] && dir) begin
         return ACT_EXTRACT;
      end else if (c[`E1TPC_CTL_LOOP] && loopOk) begin
         return ACT_LOOP;
      end else if (c[`E1TPC_CTL_SUBST] && c[`E1TPC_CTL_DSLOW]) begin
         return ACT_MW;
      end else if (c[`E1TPC_CTL_TEST]) begin
         return ACT_PATTERN;
      end else if (c[`E1TPC_CTL_SUBST]) begin
         return ACT_IDLE;
      end else begin
         return ACT_INVERT;
      end
   endfunction

   // ********************************************************
   // Microprocessor side
   // ********************************************************
   assign upCmdWrite = upReq.wr && upReq.addr == `E1TPC_OFF_ADDRCMD;
   assign indAddr = addrCmd_reg[6:0];

   // Function enable register
   always_ff @(posedge mclk) begin
      if (reset) begin
         perSlotEnable_reg <= 1'b0;
      end else if (ce && upReq.wr && upReq.addr == `E1TPC_OFF_CONFIG) begin
         perSlotEnable_reg <= upReq.data[`E1TPC_CFG_ENABLE];
      end
   end

   // Command register; a command while busy is ignored to protect the cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         addrCmd_reg <= `E1TPC_RESET_BYTE;
      end else if (ce && upCmdWrite && state_reg == ST_IDLE) begin
         addrCmd_reg <= upReq.data;
      end
   end

   // Indirect cycle sequencer, busy lasts the whole cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         cycleCnt_reg <= 8'h00;
      end else if (ce) begin
         case (state_reg)
            ST_IDLE: begin
               if (upCmdWrite) begin
                  state_reg <= ST_BUSY;
                  cycleCnt_reg <= 8'(`E1TPC_CYCLE_CLKS - 1);
               end
            end
            ST_BUSY: begin
               if (cycleCnt_reg == 8'h00) begin
                  state_reg <= ST_IDLE;
               end else begin
                  cycleCnt_reg <= cycleCnt_reg - 8'h01;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Data buffer: host writes when idle, read result lands at cycle end
   always_ff @(posedge mclk) begin
      if (reset) begin
         dataBuf_reg <= `E1TPC_RESET_BYTE;
      end else if (ce) begin
         if (state_reg == ST_BUSY && cycleCnt_reg == 8'h00
             && addrCmd_reg[`E1TPC_CMD_READ]) begin
            case (regionOf(indAddr))
               REG_CTRL: dataBuf_reg <= slotCtrl_reg[indAddr[4:0]];
               REG_IDLE: dataBuf_reg <= slotIdle_reg[indAddr[4:0]];
               REG_SIG: dataBuf_reg <= slotSig_reg[indAddr[4:0]];
               default: dataBuf_reg <= 8'h00;
            endcase
         end else if (upReq.wr && upReq.addr == `E1TPC_OFF_DATABUF
                      && state_reg == ST_IDLE) begin
            dataBuf_reg <= upReq.data;
         end
      end
   end

   // Indirect storage written at cycle end from the buffer
   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < 32; i++) begin
            slotCtrl_reg[i] <= 8'h00;
            slotIdle_reg[i] <= 8'h00;
            slotSig_reg[i] <= 8'h00;
         end
      end else if (ce && state_reg == ST_BUSY && cycleCnt_reg == 8'h00
                   && !addrCmd_reg[`E1TPC_CMD_READ]) begin
         case (regionOf(indAddr))
            REG_CTRL: slotCtrl_reg[indAddr[4:0]] <= dataBuf_reg;
            REG_IDLE: slotIdle_reg[indAddr[4:0]] <= dataBuf_reg;
            REG_SIG: slotSig_reg[indAddr[4:0]] <= {3'b000, dataBuf_reg[4:0]};
            default: ;
         endcase
      end
   end

   // Read port, reserved bits and unmapped offsets read zero
   always_ff @(posedge mclk) begin
      if (reset) begin
         upRdData_reg <= 8'h00;
      end else if (ce && upReq.rd) begin
         if (upReq.addr == `E1TPC_OFF_CONFIG) begin
            upRdData_reg <= {7'h00, perSlotEnable_reg};
         end else if (upReq.addr == `E1TPC_OFF_STATUS) begin
            upRdData_reg <= {state_reg == ST_BUSY, 7'h00};
         end else if (upReq.addr == `E1TPC_OFF_ADDRCMD) begin
            upRdData_reg <= addrCmd_reg;
         end else if (upReq.addr == `E1TPC_OFF_DATABUF) begin
            upRdData_reg <= dataBuf_reg;
         end else begin
            upRdData_reg <= 8'h00;
         end
      end
   end

   // ********************************************************
   // Serial slot framing
   // ********************************************************
   // Two flops on every pin before use
   always_ff @(posedge mclk) begin
      if (reset) begin
         pinS1_reg <= 4'h0;
         pinS2_reg <= 4'h0;
         clkPrev_reg <= 1'b0;
      end else if (ce) begin
         pinS1_reg <= {transmitSystemClock, transmitFramePulse,
                       transmitSystemDataInput, transmitSignallingInput};
         pinS2_reg <= pinS1_reg;
         clkPrev_reg <= pinS2_reg[3];
      end
   end

   // Bit position of the bit taken on this edge
   assign sysEdge = pinS2_reg[3] && !clkPrev_reg;
   assign framePin = pinS2_reg[2];
   assign curBit = framePin ? 3'd0 : bitCnt_reg + 3'd1;
   assign curSlot = framePin ? 5'd0 : (bitCnt_reg == 3'd7 ? slot_reg + 5'd1 : slot_reg);
   assign fullByte = {dataShift_reg, pinS2_reg[1]};
   assign fullSig = {sigShift_reg, pinS2_reg[0]};

   // Counters and shifters; milliwatt phase steps once per frame
   always_ff @(posedge mclk) begin
      if (reset) begin
         bitCnt_reg <= 3'd7;
         slot_reg <= 5'd31;
         mwPhase_reg <= 3'd0;
         dataShift_reg <= 7'h00;
         sigShift_reg <= 3'h0;
      end else if (ce && sysEdge) begin
         bitCnt_reg <= curBit;
         slot_reg <= curSlot;
         dataShift_reg <= fullByte[6:0];
         sigShift_reg <= fullSig[2:0];
         if (curBit == 3'd0 && curSlot == 5'd0) begin
            mwPhase_reg <= mwPhase_reg + 3'd1;
         end
      end
   end

   // Settings caught at a slot's first bit hold for the whole slot
   always_ff @(posedge mclk) begin
      if (reset) begin
         curCtrl_reg <= 8'h00;
         curIdle_reg <= 8'h00;
         curSig_reg <= 8'h00;
      end else if (ce && sysEdge && curBit == 3'd0) begin
         curCtrl_reg <= slotCtrl_reg[curSlot];
         curIdle_reg <= slotIdle_reg[curSlot];
         curSig_reg <= slotSig_reg[curSlot];
      end
   end

   // ********************************************************
   // Payload conditioning
   // ********************************************************
   always_comb begin
      action = ACT_PASS;
      if (perSlotEnable_reg) begin
         action = pickAction(curCtrl_reg, patternDirectionSelect,
                             rxClockMaster || slaveClocksShared);
      end
      case (action)
         ACT_LOOP: condByte = loopRxByte;
         ACT_MW: condByte = curCtrl_reg[`E1TPC_CTL_DSHIGH]
                            ? 8'(`E1TPC_MW_ULAW >> {mwPhase_reg, 3'b000})
                            : 8'(`E1TPC_MW_ALAW >> {mwPhase_reg, 3'b000});
         ACT_PATTERN: condByte = patGenByte;
         ACT_IDLE: condByte = curIdle_reg;
         ACT_INVERT: begin
            case (curCtrl_reg[`E1TPC_CTL_DSHIGH:`E1TPC_CTL_DSLOW])
               2'b10: condByte = fullByte ^ `E1TPC_MASK_ODD;
               2'b01: condByte = fullByte ^ `E1TPC_MASK_EVEN;
               2'b11: condByte = fullByte ^ `E1TPC_MASK_ALL;
               default: condByte = fullByte;
            endcase
         end
         default: condByte = fullByte;
      endcase
      // Stored signalling only under CAS and with per-slot functions on
      if (casEnabled && perSlotEnable_reg && slot_reg != 5'd0
          && curSig_reg[`E1TPC_SIG_SOURCE]) begin
         condSig = curSig_reg[3:0];
      end else begin
         condSig = fullSig;
      end
   end

   // Pattern handshakes: one byte per marked slot keeps both streams contiguous
   always_ff @(posedge mclk) begin
      if (reset) begin
         patGenTake_reg <= 1'b0;
         patDetValid_reg <= 1'b0;
         patDetByte_reg <= 8'h00;
      end else if (ce) begin
         patGenTake_reg <= sysEdge && curBit == 3'd7 && action == ACT_PATTERN;
         patDetValid_reg <= sysEdge && curBit == 3'd7 && action == ACT_EXTRACT;
         if (sysEdge && curBit == 3'd7 && action == ACT_EXTRACT) begin
            patDetByte_reg <= fullByte;
         end
      end
   end

   // Pending word; a new slot finding it still held counts as overflow
   always_ff @(posedge mclk) begin
      if (reset) begin
         pend_reg <= '0;
         pendValid_reg <= 1'b0;
         overflow_reg <= 1'b0;
      end else if (ce) begin
         if (sysEdge && curBit == 3'd7) begin
            pend_reg <= '{slot: curSlot, sig: condSig, data: condByte};
            pendValid_reg <= 1'b1;
            if (pendValid_reg && !fifoInReady) begin
               overflow_reg <= 1'b1;
            end
         end else if (fifoInReady) begin
            pendValid_reg <= 1'b0;
         end
      end
   end

   // ********************************************************
   // Output buffering
   // ********************************************************
   assign fifoPop = fifoOutValid && (!outValid_reg || outReady);

   e1tpc_fifo #(
      .WIDTH($bits(e1tpc_word_s)),
      .DEPTH(8)
   ) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .ce(ce),
      .inData(pend_reg),
      .inValid(pendValid_reg),
      .inReady(fifoInReady),
      .outData(fifoOut),
      .outValid(fifoOutValid),
      .outReady(fifoPop)
   );

   // Registered output stage so the ports come from flops
   always_ff @(posedge mclk) begin
      if (reset) begin
         outWord_reg <= '0;
         outValid_reg <= 1'b0;
         fifoRoom_reg <= 1'b1;
      end else if (ce) begin
         fifoRoom_reg <= fifoInReady;
         if (fifoPop) begin
            outWord_reg <= fifoOut;
            outValid_reg <= 1'b1;
         end else if (outReady) begin
            outValid_reg <= 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// ### dv/e1tpc_cond_sva.sv
// Port checks of the transmit slot conditioner
`timescale 1ns/1ps
`default_nettype none
`include "e1tpc_map.svh"
module e1tpc_cond_sva
   import e1tpc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire e1tpc_up_s upReq,
   input wire logic [7:0] upRdData_reg,
   input wire logic patGenTake_reg,
   input wire logic [7:0] patDetByte_reg,
   input wire logic patDetValid_reg,
   input wire logic overflow_reg
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // ********************************************************
   // Shadow busy count: busy is only visible through status reads
   // ********************************************************
   logic [7:0] busy_reg;
   logic stRd;
   assign stRd = ce && upReq.rd && upReq.addr == `E1TPC_OFF_STATUS;
   // Commands during busy are dropped, so only an idle shadow restarts
   always_ff @(posedge mclk) begin
      if (reset) begin
         busy_reg <= 8'h00;
      end else if (ce && busy_reg != 8'h00) begin
         busy_reg <= busy_reg - 8'h01;
      end else if (ce && upReq.wr && upReq.addr == `E1TPC_OFF_ADDRCMD) begin
         busy_reg <= 8'(`E1TPC_CYCLE_CLKS);
      end
   end
   chk_busy_shown: assert property (stRd && busy_reg != 8'h00 |=> upRdData_reg[7])
      else $error("busy not shown");
   chk_busy_ends: assert property (stRd && busy_reg == 8'h00 |=> !upRdData_reg[7])
      else $error("busy held too long");
   chk_rd_holds: assert property (!(ce && upReq.rd) |=> $stable(upRdData_reg))
      else $error("read data moved");
   chk_gen_pulse: assert property (ce && patGenTake_reg |=> !patGenTake_reg)
      else $error("take pulse too long");
   chk_det_pulse: assert property (ce && patDetValid_reg |=> !patDetValid_reg)
      else $error("extract pulse too long");
   chk_det_hold: assert property ($changed(patDetByte_reg) |-> patDetValid_reg)
      else $error("extract byte moved alone");
   chk_dir_excl: assert property (patGenTake_reg |-> !patDetValid_reg)
      else $error("insert and extract together");
   chk_ovf_sticky: assert property (overflow_reg |=> overflow_reg)
      else $error("overflow cleared");
   cover property (stRd ##1 upRdData_reg[7]);
   cover property (patDetValid_reg);
   cover property ($rose(overflow_reg));
endmodule
bind e1tpc_conditioner e1tpc_cond_sva chk (.mclk(mclk), .reset(reset), .ce(ce),
   .upReq(upReq), .upRdData_reg(upRdData_reg), .patGenTake_reg(patGenTake_reg),
   .patDetByte_reg(patDetByte_reg), .patDetValid_reg(patDetValid_reg),
   .overflow_reg(overflow_reg));
`default_nettype wire

// ### dv/e1tpc_tdm_src.sv
// Backplane model: serial transmit slots, signalling and frame pulse
`timescale 1ns/1ps
`default_nettype none
module e1tpc_tdm_src (
   input wire logic mclk,
   output logic bitClk = 1'b0,
   output logic framePulse = 1'b0,
   output logic dataOut = 1'b0,
   output logic sigOut = 1'b0
);
   // One frame; each clock phase four mclk, above the three the sync needs
   task automatic send_frame(input logic [31:0][7:0] pay, input logic [31:0][3:0] sig);
      for (int s = 0; s < 32; s++) begin
         for (int b = 7; b >= 0; b--) begin
            @(posedge mclk);
            bitClk <= 1'b0;
            dataOut <= pay[s][b]; // Most significant bit first
            sigOut <= b < 4 ? sig[s][b] : 1'b0; // A to D in the last four bits
            framePulse <= s == 0 && b == 7;
            repeat (4) @(posedge mclk);
            bitClk <= 1'b1;
            repeat (3) @(posedge mclk);
         end
      end
      @(posedge mclk);
      bitClk <= 1'b0;
      framePulse <= 1'b0;
      dataOut <= ~dataOut; // Released lines never keep the last bit
      sigOut <= ~sigOut;
   endtask
endmodule
`default_nettype wire

// ### dv/e1_tx_timeslot_conditioner_test.sv
// Self-checking bench of the transmit slot conditioner
`timescale 1ns/1ps
`default_nettype none
`include "e1tpc_map.svh"
module e1_tx_timeslot_conditioner_test;
   import e1tpc_pkg::*;
   logic mclk, tsClk, tsFp, tsData, tsSig, genTake, detValid, outValid, room, ovf;
   logic reset = 1'b1, ce = 1'b1, dirSel = 1'b0, cas = 1'b0, rxm = 1'b0, shr = 1'b0;
   logic outReady = 1'b1;
   logic [7:0] rdData, detByte, rdByte, loopByte = 8'h00, genByte = 8'h00;
   e1tpc_up_s upReq = '0;
   e1tpc_word_s outWord;
   int fail_count = 0, n_compared = 0, frameNo = 0;
   e1tpc_word_s outQ[$];
   logic [7:0] detQ[$];
   e1tpc_tdm_src src (.mclk(mclk), .bitClk(tsClk), .framePulse(tsFp), .dataOut(tsData),
      .sigOut(tsSig));
   e1tpc_conditioner dut (.mclk(mclk), .reset(reset), .ce(ce), .upReq(upReq),
      .upRdData_reg(rdData), .transmitSystemClock(tsClk), .transmitFramePulse(tsFp),
      .transmitSystemDataInput(tsData), .transmitSignallingInput(tsSig),
      .patternDirectionSelect(dirSel), .casEnabled(cas), .rxClockMaster(rxm),
      .slaveClocksShared(shr), .loopRxByte(loopByte), .patGenByte(genByte),
      .patGenTake_reg(genTake), .patDetByte_reg(detByte), .patDetValid_reg(detValid),
      .outWord_reg(outWord), .outValid_reg(outValid), .outReady(outReady),
      .fifoRoom_reg(room), .overflow_reg(ovf));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Collect words and extracted bytes; step the generator on each take
   always @(posedge mclk) begin
      if (outValid === 1'b1 && outReady === 1'b1) outQ.push_back(outWord);
      if (detValid === 1'b1) detQ.push_back(detByte);
      if (genTake === 1'b1) genByte <= genByte + 8'h11;
   end
   // ********************************************************
   // Comparison, verdict and register access
   // ********************************************************
   task automatic give_verdict;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // Two cycles per access so a request is never assigned twice in a step
   task automatic bus(input logic w, input logic [7:0] a, d);
      upReq <= '{wr: w, rd: !w, addr: a, data: d};
      @(posedge mclk);
      upReq <= '0;
      @(posedge mclk);
      rdByte = rdData;
   endtask
   task automatic ind(input logic rd, input logic [6:0] a, input logic [7:0] d);
      int n;
      if (!rd) bus(1'b1, `E1TPC_OFF_DATABUF, d); // Data before command
      bus(1'b1, `E1TPC_OFF_ADDRCMD, {rd, a});
      bus(1'b0, `E1TPC_OFF_STATUS, 8'h00);
      check("busy", rdByte & 8'h80, 8'h80);
      for (n = 0; n < 70 && rdByte[7] !== 1'b0; n++) bus(1'b0, `E1TPC_OFF_STATUS, 8'h00);
      if (rdByte !== 8'h00) begin
         check("busy end", rdByte, 8'h00);
         give_verdict();
      end
      if (rd) bus(1'b0, `E1TPC_OFF_DATABUF, 8'h00);
   endtask
   // Random slot settings, one frame, then every slot word against the model, or only overflow and room when stalled
   task automatic run_frame(input logic en, d, m, s2, stall);
      logic [31:0][7:0] ctl, idl, pay, sig;
      logic [31:0][3:0] pin;
      logic [7:0] e, base, xq[$];
      logic [63:0] mw;
      int g;
      bus(1'b1, `E1TPC_OFF_CONFIG, {7'h00, en});
      dirSel <= d;
      rxm <= m;
      shr <= s2;
      cas <= d;
      outReady <= !stall;
      loopByte <= 8'($urandom);
      for (int s = 0; s < 32; s++) begin
         ctl[s] = 8'($urandom) & 8'hbc;
         idl[s] = 8'($urandom);
         pay[s] = 8'($urandom);
         sig[s] = 8'($urandom) & 8'h1f;
         pin[s] = 4'($urandom);
         ind(1'b0, 7'h20 + 7'(s), ctl[s]);
         ind(1'b0, 7'h40 + 7'(s), idl[s]);
         if (s > 0) ind(1'b0, 7'h60 + 7'(s), sig[s]);
      end
      outQ.delete();
      detQ.delete();
      frameNo++;
      g = 0;
      base = genByte;
      src.send_frame(pay, pin);
      repeat (40) @(posedge mclk);
      if (stall) begin
         check("overflow", {ovf, room, 6'h00}, 8'h80);
         return;
      end
      check("words", 8'(outQ.size()), 8'h20);
      for (int s = 0; s < 32 && outQ.size() == 32; s++) begin
         e = pay[s];
         mw = ctl[s][5] ? `E1TPC_MW_ULAW : `E1TPC_MW_ALAW;
         if (en && ctl[s][3] && d) xq.push_back(pay[s]);
         else if (en && ctl[s][2] && (m || s2)) e = loopByte;
         else if (en && ctl[s][7] && ctl[s][4]) e = 8'(mw >> (8 * (frameNo % 8)));
         else if (en && ctl[s][3]) begin
            e = base + 8'(g * 17);
            g++;
         end else if (en && ctl[s][7]) e = idl[s];
         else if (en) e = pay[s] ^ (ctl[s][5] ? 8'h55 : 8'h00) ^ (ctl[s][4] ? 8'haa : 8'h00);
         check("data", outQ[s].data, e);
         check("slot", {3'h0, outQ[s].slot}, 8'(s));
         e = {4'h0, d && en && s > 0 && sig[s][4] ? sig[s][3:0] : pin[s]};
         check("signalling", {4'h0, outQ[s].sig}, e);
      end
      check("extract count", 8'(detQ.size()), 8'(xq.size()));
      foreach (xq[i]) if (i < detQ.size()) check("extracted", detQ[i], xq[i]);
   endtask
   // ********************************************************
   // Main sequence
   // ********************************************************
   initial begin
      void'($urandom(32'h0a0ad875));
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      // Direct registers reset to zero; 0x64 lies outside the map
      for (int a = 8'h60; a < 8'h65; a++) begin
         bus(1'b0, 8'(a), 8'h00);
         check("reset value", rdByte, 8'h00);
      end
      // Clock enable low must drop a config write
      ce <= 1'b0;
      bus(1'b1, `E1TPC_OFF_CONFIG, 8'h01);
      ce <= 1'b1;
      bus(1'b0, `E1TPC_OFF_CONFIG, 8'h00);
      check("frozen config", rdByte, 8'h00);
      // Slot 0 has no signalling byte: write dropped, read gives zero
      ind(1'b0, 7'h60, 8'h5a);
      ind(1'b1, 7'h60, 8'h00);
      check("no slot 0 signalling", rdByte, 8'h00);
      ind(1'b0, 7'h5f, 8'ha5);
      ind(1'b1, 7'h5f, 8'h00);
      check("idle code", rdByte, 8'ha5);
      ind(1'b0, 7'h7f, 8'hff);
      ind(1'b1, 7'h7f, 8'h00);
      check("signalling byte", rdByte, 8'h1f);
      run_frame(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      run_frame(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      run_frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      run_frame(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      run_frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
